// >>> logic/logic_and_branch_decode.sv
// Decode/execute of conjunction, relative branch, call-with-link and float-false branches
// Summary of operation
// - Register conjunction writes rs AND rt to rd
// - Immediate conjunction zero-extends immediate, writes rt
// - Equal branch with both registers zero always taken
// - Target is slot address plus shifted offset
// - Delay slot executes before PC takes target
// - Branch-group sub-op 10001 source zero always calls
// - Call writes branch address plus 8 to reg 31
// - Float branch fields: cc, nullify, polarity
// - False branch taken when selected code is 0
// - Likely form nullifies slot when not taken
// - Float branches report unusable/reserved/unimplemented
// - Three-bit select picks one of eight codes
`timescale 1ns/1ps
module logic_and_branch_decode
    import logic_branch_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Instruction issue
    input  wire logic                  issue_valid,
    input  wire logic [IW-1:0]         instr,
    input  wire logic [XLEN-1:0]       instr_pc,
    // Operands read from the register file
    input  wire logic [XLEN-1:0]       src_a,
    input  wire logic [XLEN-1:0]       src_b,
    // Float unit state
    input  wire logic [7:0]            fp_cond,
    input  wire logic                  fpu_usable,
    input  wire logic                  fpu_present,
    input  wire logic                  eight_cc_support,
    // Register write-back
    output logic                       wb_en,
    output logic [4:0]                 wb_reg,
    output logic [XLEN-1:0]            wb_data,
    // Program flow
    output logic [XLEN-1:0]            pc_out,
    output logic                       pc_redirect,
    output logic                       slot_nullify,
    output logic                       decoded,
    // Exceptions
    output logic                       exc_valid,
    output logic_branch_pkg::exc_code_t exc_code
);
    import logic_branch_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic            wb_en;
        logic [4:0]      wb_reg;
        logic [XLEN-1:0] wb_data;
        logic [XLEN-1:0] pc;
        logic            redirect;
        logic            nullify;
        logic            decoded;
        logic            exc;
        exc_code_t       code;
        logic            pend;
        logic [XLEN-1:0] pend_target;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    function automatic logic [4:0] fld5(input logic [IW-1:0] i, input int lo);
        fld5 = i[lo +: 5];
    endfunction : fld5

    logic [5:0]       op;
    logic [5:0]       fn;
    logic [2:0]       cc_sel;
    logic [XLEN-1:0]  target;
    logic [XLEN-1:0]  link_addr;
    logic             is_and;
    logic             is_bitwise_conjunction_imm;
    logic             is_uncond;
    logic             is_call;
    logic             is_fbr;
    logic             fp_taken;

    assign op        = instr[OP_HI:OP_LO];
    assign fn        = instr[FN_HI:FN_LO];
    assign cc_sel    = instr[CC_HI:CC_LO];
    assign is_and    = op == OP_REGISTER_FORMAT && fn == FN_CONJ && fld5(instr, SA_LO) == ZERO_FIELD;
    assign is_bitwise_conjunction_imm   = op == OP_CONJ_IMM;
    assign is_uncond = op == OP_EQUAL_COMPARE && fld5(instr, RS_LO) == ZERO_FIELD
                       && fld5(instr, RT_LO) == ZERO_FIELD;
    assign is_call   = op == OP_BRANCH_GROUP && fld5(instr, RT_LO) == SUB_NONNEG_LINK
                       && fld5(instr, RS_LO) == ZERO_FIELD;
    assign is_fbr    = op == OP_FLOAT_UNIT && fld5(instr, RS_LO) == SUB_FLOAT_BRANCH
                       && !instr[TF_BIT];
    assign fp_taken  = fp_cond[cc_sel] == 1'b0;

    branch_target_calc u_target (
        .branch_pc (instr_pc),
        .offset    (instr[IMM_W-1:0]),
        .target    (target),
        .link_addr (link_addr)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.wb_en    = 1'b0;
        st_next.redirect = 1'b0;
        st_next.nullify  = 1'b0;
        st_next.decoded  = 1'b0;
        st_next.exc      = 1'b0;
        st_next.code     = EXC_NONE;
        if (issue_valid) begin
            st_next.pc = instr_pc;
            // Delay slot done: PC takes the held target
            if (st_reg.pend) begin
                st_next.pc       = st_reg.pend_target;
                st_next.redirect = 1'b1;
                st_next.pend     = 1'b0;
            end
            if (is_and) begin
                st_next.decoded = 1'b1;
                st_next.wb_en   = 1'b1;
                st_next.wb_reg  = fld5(instr, RD_LO);
                st_next.wb_data = src_a & src_b;
            end else if (is_bitwise_conjunction_imm) begin
                st_next.decoded = 1'b1;
                st_next.wb_en   = 1'b1;
                st_next.wb_reg  = fld5(instr, RT_LO);
                st_next.wb_data = src_a & {{(XLEN-IMM_W){1'b0}}, instr[IMM_W-1:0]};
            end else if (is_uncond || is_call) begin
                st_next.decoded     = 1'b1;
                st_next.pend        = 1'b1;
                st_next.pend_target = target;
                if (is_call) begin
                    st_next.wb_en   = 1'b1;
                    st_next.wb_reg  = LINK_REG;
                    st_next.wb_data = link_addr;
                end
            end else if (is_fbr) begin
                st_next.decoded = 1'b1;
                if (!fpu_present) begin
                    st_next.exc  = 1'b1;
                    st_next.code = EXC_RESERVED;
                end else if (!fpu_usable) begin
                    st_next.exc  = 1'b1;
                    st_next.code = EXC_COP_UNUSABLE;
                end else if (!eight_cc_support && cc_sel != 3'h0) begin
                    st_next.exc  = 1'b1;
                    st_next.code = EXC_UNIMPL_OP;
                end else if (fp_taken) begin
                    st_next.pend        = 1'b1;
                    st_next.pend_target = target;
                end else if (instr[ND_BIT]) begin
                    st_next.nullify = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{wb_en: 1'b0, wb_reg: 5'h00, wb_data: '0, pc: RESET_PC, redirect: 1'b0,
                        nullify: 1'b0, decoded: 1'b0, exc: 1'b0, code: EXC_NONE, pend: 1'b0,
                        pend_target: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_en        = st_reg.wb_en;
    assign wb_reg       = st_reg.wb_reg;
    assign wb_data      = st_reg.wb_data;
    assign pc_out       = st_reg.pc;
    assign pc_redirect  = st_reg.redirect;
    assign slot_nullify = st_reg.nullify;
    assign decoded      = st_reg.decoded;
    assign exc_valid    = st_reg.exc;
    assign exc_code     = st_reg.code;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_and_result: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_and |=> wb_en && wb_data == $past(src_a & src_b))
        else $error("register conjunction result wrong");
    a_bitwise_conjunction_imm_result: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_bitwise_conjunction_imm |=> wb_en && wb_reg == $past(instr[RT_HI:RT_LO])
        && wb_data[XLEN-1:IMM_W] == '0)
        else $error("immediate conjunction result wrong");
    a_uncond_taken: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_uncond && !st_reg.pend ##1 issue_valid |=> pc_redirect)
        else $error("unconditional branch not taken");
    a_target_calc: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_uncond |=> st_reg.pend_target == $past(instr_pc) + SLOT_STEP
        + {{(XLEN-IMM_W-SHIFT_W){$past(instr[IMM_W-1])}}, $past(instr[IMM_W-1:0]), 2'b00})
        else $error("branch target wrong");
    a_slot_first: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && (is_uncond || is_call) && !st_reg.pend |=> !pc_redirect)
        else $error("redirect before delay slot");
    a_call_link: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_call |=> wb_en && wb_reg == LINK_REG
        && wb_data == $past(instr_pc) + LINK_STEP)
        else $error("link write wrong");
    a_false_taken: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_fbr && fpu_present && fpu_usable && cc_sel == 3'h0
        && !fp_cond[0] |=> st_reg.pend)
        else $error("float false branch not taken");
    a_likely_null: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_fbr && instr[ND_BIT] && fpu_present && fpu_usable
        && (eight_cc_support || cc_sel == 3'h0) && fp_cond[cc_sel] |=> slot_nullify)
        else $error("likely slot not nullified");
    a_fpu_unusable: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && is_fbr && fpu_present && !fpu_usable |=> exc_valid
        && exc_code == EXC_COP_UNUSABLE)
        else $error("unusable exception missing");
    a_conj_no_exc: assert property (@(posedge ref_clk) disable iff (rst)
        issue_valid && (is_and || is_bitwise_conjunction_imm) |=> !exc_valid)
        else $error("conjunction raised exception");
    c_call: cover property (@(posedge ref_clk) disable iff (rst) issue_valid && is_call ##1 issue_valid ##1 pc_redirect);
    c_likely: cover property (@(posedge ref_clk) disable iff (rst) slot_nullify);
    c_fexc: cover property (@(posedge ref_clk) disable iff (rst) exc_valid);
    c_and: cover property (@(posedge ref_clk) disable iff (rst) issue_valid && is_and);
endmodule : logic_and_branch_decode

// >>> logic/logic_branch_pkg.sv
// Encodings, field positions and sizes for the logic and branch decoder
package logic_branch_pkg;
    localparam int XLEN = 64;
    localparam int IW   = 32;
    // Major opcodes
    localparam logic [5:0] OP_REGISTER_FORMAT = 6'h00;
    localparam logic [5:0] OP_BRANCH_GROUP    = 6'h01;
    localparam logic [5:0] OP_EQUAL_COMPARE   = 6'h04;
    localparam logic [5:0] OP_CONJ_IMM        = 6'h0C;
    localparam logic [5:0] OP_FLOAT_UNIT      = 6'h11;
    // Minor codes
    localparam logic [5:0] FN_CONJ            = 6'h24;
    localparam logic [4:0] SUB_NONNEG_LINK    = 5'h11;
    localparam logic [4:0] SUB_FLOAT_BRANCH   = 5'h08;
    localparam logic [4:0] ZERO_FIELD         = 5'h00;
    localparam logic [4:0] LINK_REG           = 5'h1F;
    // Field positions
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int RS_HI = 25;
    localparam int RS_LO = 21;
    localparam int RT_HI = 20;
    localparam int RT_LO = 16;
    localparam int RD_HI = 15;
    localparam int RD_LO = 11;
    localparam int SA_HI = 10;
    localparam int SA_LO = 6;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;
    localparam int CC_HI = 20;
    localparam int CC_LO = 18;
    localparam int ND_BIT = 17;
    localparam int TF_BIT = 16;
    localparam int IMM_W  = 16;
    localparam int SHIFT_W = 2;
    localparam logic [XLEN-1:0] SLOT_STEP = 64'h0000_0000_0000_0004;
    localparam logic [XLEN-1:0] LINK_STEP = 64'h0000_0000_0000_0008;
    localparam logic [XLEN-1:0] RESET_PC  = 64'h0000_0000_0000_0000;
    // Exception codes reported to the pipeline
    typedef enum logic [1:0] {
        EXC_NONE, EXC_COP_UNUSABLE, EXC_RESERVED, EXC_UNIMPL_OP
    } exc_code_t;
endpackage : logic_branch_pkg

// >>> logic/branch_target_calc.sv
// Branch target and link address arithmetic
`timescale 1ns/1ps
module branch_target_calc
    import logic_branch_pkg::*;
(
    // Branch address and offset
    input  wire logic [XLEN-1:0]  branch_pc,
    input  wire logic [IMM_W-1:0] offset,
    // Results
    output logic [XLEN-1:0]       target,
    output logic [XLEN-1:0]       link_addr
);
    import logic_branch_pkg::*;
    logic [IMM_W+SHIFT_W-1:0] shifted;
    assign shifted   = {offset, {SHIFT_W{1'b0}}};
    // Relative to the delay-slot address
    assign target    = branch_pc + SLOT_STEP
                       + {{(XLEN-IMM_W-SHIFT_W){shifted[IMM_W+SHIFT_W-1]}}, shifted};
    assign link_addr = branch_pc + LINK_STEP;
endmodule : branch_target_calc

// >>> dv/testbench.sv
// Self-checking testbench for the logic and branch decoder
`timescale 1ns/1ps
module testbench;
    import logic_branch_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic             ref_clk          = 1'b0;
    logic             rst              = 1'b1;
    logic             issue_valid      = 1'b0;
    logic [IW-1:0]    instr            = '0;
    logic [XLEN-1:0]  instr_pc         = '0;
    logic [XLEN-1:0]  src_a            = '0;
    logic [XLEN-1:0]  src_b            = '0;
    logic [7:0]       fp_cond          = '0;
    logic             fpu_usable       = 1'b1;
    logic             fpu_present      = 1'b1;
    logic             eight_cc_support = 1'b1;
    logic             wb_en;
    logic [4:0]       wb_reg;
    logic [XLEN-1:0]  wb_data;
    logic [XLEN-1:0]  pc_out;
    logic             pc_redirect;
    logic             slot_nullify;
    logic             decoded;
    logic             exc_valid;
    exc_code_t        exc_code;
    logic [7:0]       fc               = 8'h00;
    logic             fu               = 1'b1;
    logic             fpr              = 1'b1;
    logic             e8               = 1'b1;
    int               err_total        = 0;
    int               tests_run        = 0;
    int               cycles           = 0;

    logic_and_branch_decode i_logic_and_branch_decode (
        .ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr), .instr_pc(instr_pc),
        .src_a(src_a), .src_b(src_b), .fp_cond(fp_cond), .fpu_usable(fpu_usable),
        .fpu_present(fpu_present), .eight_cc_support(eight_cc_support), .wb_en(wb_en),
        .wb_reg(wb_reg), .wb_data(wb_data), .pc_out(pc_out), .pc_redirect(pc_redirect),
        .slot_nullify(slot_nullify), .decoded(decoded), .exc_valid(exc_valid), .exc_code(exc_code)
    );

    always #4 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rtype(input logic [4:0] s, input logic [4:0] t, input logic [4:0] d);
        return {OP_REGISTER_FORMAT, s, t, d, ZERO_FIELD, FN_CONJ};
    endfunction : rtype

    function automatic logic [31:0] itype(input logic [5:0] op, input logic [4:0] s, input logic [4:0] t,
                                          input logic [15:0] imm);
        return {op, s, t, imm};
    endfunction : itype

    function automatic logic [31:0] fbr(input logic [2:0] cc, input logic nd, input logic [15:0] off);
        return {OP_FLOAT_UNIT, SUB_FLOAT_BRANCH, cc, nd, 1'b0, off};
    endfunction : fbr

    function automatic logic [63:0] tgt(input logic [63:0] pc, input logic [15:0] off);
        return pc + 64'h4 + {{46{off[15]}}, off, 2'b00};
    endfunction : tgt

    // Drives one cycle; on return the outputs answer the previous call
    task automatic put(input logic v, input logic [31:0] ins, input logic [63:0] pc,
                       input logic [63:0] a = '0, input logic [63:0] b = '0);
        @(posedge ref_clk);
        issue_valid      <= v;
        instr            <= ins;
        instr_pc         <= pc;
        src_a            <= a;
        src_b            <= b;
        fp_cond          <= fc;
        fpu_usable       <= fu;
        fpu_present      <= fpr;
        eight_cc_support <= e8;
        @(negedge ref_clk);
    endtask : put

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_and_reg;
        put(1'b1, rtype(5'h03, 5'h04, 5'h09), 64'h100, 64'hF0F0_1234_5678_FFFF, 64'h0FF0_FFFF_0000_8001);
        put(1'b0, '0, '0);
        chk("and_wb_en", 64'h1, wb_en);
        chk("and_wb_reg", 64'h9, wb_reg);
        chk("and_wb_data", 64'h00F0_1234_0000_8001, wb_data);
        chk("and_exc", 64'h0, exc_valid);
        // Nonzero shift field is not the conjunction
        put(1'b1, rtype(5'h03, 5'h04, 5'h0A) | 32'h0000_0040, 64'h108, 64'hF, 64'hF);
        put(1'b0, '0, '0);
        chk("and_sa_decoded", 64'h0, decoded);
        chk("and_sa_wb_en", 64'h0, wb_en);
    endtask : t_and_reg

    task automatic t_and_imm;
        put(1'b1, itype(OP_CONJ_IMM, 5'h02, 5'h07, 16'h8F0F), 64'h104, 64'hFFFF_FFFF_FFFF_FFFF, 64'h5);
        put(1'b0, '0, '0);
        chk("bitwise_conjunction_imm_wb_reg", 64'h7, wb_reg);
        chk("bitwise_conjunction_imm_wb_data", 64'h0000_0000_0000_8F0F, wb_data);
        chk("bitwise_conjunction_imm_exc", 64'h0, exc_valid);
    endtask : t_and_imm

    task automatic t_uncond;
        put(1'b1, itype(OP_EQUAL_COMPARE, ZERO_FIELD, ZERO_FIELD, 16'hFFF0), 64'h2000);
        put(1'b1, rtype(5'h01, 5'h02, 5'h03), 64'h2004, 64'hF, 64'h3);
        chk("br_early", 64'h0, pc_redirect);
        chk("br_decoded", 64'h1, decoded);
        put(1'b0, '0, '0);
        chk("br_redirect", 64'h1, pc_redirect);
        chk("br_target", tgt(64'h2000, 16'hFFF0), pc_out);
        chk("br_slot_data", 64'h3, wb_data);
    endtask : t_uncond

    task automatic t_call;
        put(1'b1, itype(OP_BRANCH_GROUP, ZERO_FIELD, SUB_NONNEG_LINK, 16'h0010), 64'h3000);
        put(1'b1, 32'h0, 64'h3004);
        chk("call_wb_reg", LINK_REG, wb_reg);
        chk("call_wb_data", 64'h3008, wb_data);
        chk("call_early", 64'h0, pc_redirect);
        put(1'b0, '0, '0);
        chk("call_redirect", 64'h1, pc_redirect);
        chk("call_target", tgt(64'h3000, 16'h0010), pc_out);
    endtask : t_call

    task automatic t_float_false;
        for (int c = 0; c < 8; c++) begin
            fc = ~(8'h01 << c);
            // Condition codes settle a cycle ahead of the branch
            put(1'b0, '0, '0);
            put(1'b1, fbr(c[2:0], 1'b0, 16'h0004), 64'h5000);
            put(1'b1, 32'h0, 64'h5004);
            put(1'b0, '0, '0);
            chk("ff_redirect", 64'h1, pc_redirect);
            chk("ff_target", tgt(64'h5000, 16'h0004), pc_out);
        end
        fc = 8'h20;
        put(1'b0, '0, '0);
        put(1'b1, fbr(3'h5, 1'b0, 16'h0004), 64'h6000);
        put(1'b1, 32'h0, 64'h6004);
        chk("ffn_decoded", 64'h1, decoded);
        chk("ffn_nullify", 64'h0, slot_nullify);
        put(1'b0, '0, '0);
        chk("ffn_redirect", 64'h0, pc_redirect);
        // True-sense branch is not decoded here
        put(1'b1, fbr(3'h0, 1'b0, 16'h0004) | 32'h0001_0000, 64'h6100);
        put(1'b0, '0, '0);
        chk("ftrue_decoded", 64'h0, decoded);
        put(1'b0, '0, '0);
        chk("ftrue_redirect", 64'h0, pc_redirect);
    endtask : t_float_false

    task automatic t_likely(input logic [7:0] cond, input logic taken);
        fc = cond;
        put(1'b0, '0, '0);
        put(1'b1, fbr(3'h2, 1'b1, 16'h0008), 64'h7000);
        put(1'b1, 32'h0, 64'h7004);
        chk("fl_nullify", !taken, slot_nullify);
        put(1'b0, '0, '0);
        chk("fl_late_nullify", 64'h0, slot_nullify);
        chk("fl_redirect", taken, pc_redirect);
    endtask : t_likely

    task automatic t_exc(input logic p, input logic u, input logic e, input logic [2:0] cc, input exc_code_t x);
        fpr = p;
        fu = u;
        e8 = e;
        put(1'b1, fbr(cc, 1'b0, 16'h0004), 64'h8000);
        put(1'b0, '0, '0);
        chk("exc_valid", 64'h1, exc_valid);
        chk("exc_code", x, exc_code);
        fpr = 1'b1;
        fu = 1'b1;
        e8 = 1'b1;
    endtask : t_exc

    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk("reset_wb_en", 64'h0, wb_en);
        chk("reset_redirect", 64'h0, pc_redirect);
        t_and_reg();
        t_and_imm();
        t_uncond();
        t_call();
        t_float_false();
        t_likely(8'h04, 1'b0);
        t_likely(8'hFB, 1'b1);
        t_exc(1'b0, 1'b1, 1'b1, 3'h0, EXC_RESERVED);
        t_exc(1'b1, 1'b0, 1'b1, 3'h0, EXC_COP_UNUSABLE);
        t_exc(1'b1, 1'b1, 1'b0, 3'h3, EXC_UNIMPL_OP);
        end_sim();
    end
endmodule : testbench
